//--- capture_reload_timer.sv
// 16-bit timer with auto-reload, capture and baud generation behind the SFR port
`include "timer2_params.svh"

module capture_reload_timer (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   input wire logic [7:0] SFR_BIT_ADDR,
   input wire logic SFR_BIT_WR,
   input wire logic SFR_BIT_VAL,
   input wire logic SFR_BIT_RD,
   output logic SFR_BIT_RDATA,
   input wire logic TICK_SPEED_SELECT,
   input wire logic TRIGGER_PIN,
   input wire logic COUNT_INPUT_PIN,
   input wire logic OTHER_TIMER_OVF,
   output logic RX_BAUD_TICK,
   output logic TX_BAUD_TICK,
   output logic TIMER_INT_REQ
);
   timer2_pkg::ctrl_s ctrl_ff;
   timer2_pkg::ctrl_s nxt_ctrl;
   timer2_pkg::mode_e mode;
   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic [15:0] rcap_ff;
   logic [15:0] nxt_rcap;
   logic [3:0] presc_ff;
   logic half_ff;
   logic [7:0] rdata_ff;
   logic bit_rdata_ff;
   logic rx_tick_ff;
   logic tx_tick_ff;
   logic baud_mode;
   logic presc_tick;
   logic count_inc;
   logic roll;
   logic trig_act;
   logic ctrl_bit_hit;
   logic [3:0] presc_last;
   logic [7:0] ctrl_bits;
   logic wr_ctrl;
   logic wr_rcap_lo;
   logic wr_rcap_hi;
   logic wr_count_lo;
   logic wr_count_hi;
   logic bit_wr_ctrl;
   logic ovf_set;
   logic edge_set;
   logic capture_now;
   logic [7:0] rd_mux;
   logic bit_rd_mux;

   pin_edge_if trig_edge ();
   pin_edge_if cnt_edge ();

   pin_edge_detect trig_sync (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .pin_raw(TRIGGER_PIN),
      .edge_out(trig_edge.det)
   );

   pin_edge_detect cnt_sync (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .pin_raw(COUNT_INPUT_PIN),
      .edge_out(cnt_edge.det)
   );

   assign baud_mode = ctrl_ff.rx_baud_select | ctrl_ff.tx_baud_select;
   assign ctrl_bit_hit = (SFR_BIT_ADDR[7:3] == `CTRL_BIT_BASE);
   // A byte write to the control register outranks a bit write in the same cycle
   assign bit_wr_ctrl = SFR_BIT_WR & ctrl_bit_hit & ~wr_ctrl;
   assign bit_rd_mux = ctrl_bit_hit & ctrl_bits_read(ctrl_ff, SFR_BIT_ADDR[2:0]);

   // One write strobe per register keeps the priorities below readable
   always_comb begin
      wr_ctrl = 1'b0;
      wr_rcap_lo = 1'b0;
      wr_rcap_hi = 1'b0;
      wr_count_lo = 1'b0;
      wr_count_hi = 1'b0;
      if (SFR_WR) begin
         if (SFR_ADDR == `CTRL_ADDR) begin
            wr_ctrl = 1'b1;
         end else if (SFR_ADDR == `RCAP_LO_ADDR) begin
            wr_rcap_lo = 1'b1;
         end else if (SFR_ADDR == `RCAP_HI_ADDR) begin
            wr_rcap_hi = 1'b1;
         end else if (SFR_ADDR == `COUNT_LO_ADDR) begin
            wr_count_lo = 1'b1;
         end else if (SFR_ADDR == `COUNT_HI_ADDR) begin
            wr_count_hi = 1'b1;
         end
      end
   end

   always_comb begin
      if (baud_mode) begin
         mode = timer2_pkg::MODE_BAUD;
      end else if (ctrl_ff.capture_reload_select) begin
         mode = timer2_pkg::MODE_CAPTURE;
      end else begin
         mode = timer2_pkg::MODE_RELOAD;
      end
   end

   // Timer ticks: prescaler runs free so the first tick after start may come early
   assign presc_last = (TICK_SPEED_SELECT ? `TICK_DIV_FAST : `TICK_DIV_SLOW) - `PRESC_ONE;
   assign presc_tick = (presc_ff >= presc_last);

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         presc_ff <= `PRESC_RESET;
      end else if (presc_tick) begin
         presc_ff <= `PRESC_RESET;
      end else begin
         presc_ff <= presc_ff + `PRESC_ONE;
      end
   end

   // Divider runs free, so the first baud count after entry may land one clock early
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         half_ff <= 1'b0;
      end else begin
         half_ff <= ~half_ff;
      end
   end

   always_comb begin
      if (!ctrl_ff.run_control) begin
         count_inc = 1'b0;
      end else if (baud_mode) begin
         count_inc = half_ff;
      end else if (ctrl_ff.counter_select) begin
         count_inc = cnt_edge.fall;
      end else begin
         count_inc = presc_tick;
      end
   end

   assign roll = count_inc & (count_ff == `COUNT_MAX);
   // Pin capture and reload act only outside baud mode; the edge flag is set in any mode
   assign trig_act = trig_edge.fall & ctrl_ff.external_edge_enable & ~baud_mode;
   assign ovf_set = roll & ~baud_mode;
   assign edge_set = trig_edge.fall & ctrl_ff.external_edge_enable;
   assign capture_now = trig_act & (mode == timer2_pkg::MODE_CAPTURE);

   // Count: a software write beats the hardware update in the same cycle
   always_comb begin
      nxt_count = count_ff;
      if (wr_count_lo) begin
         nxt_count[7:0] = SFR_WDATA;
      end else if (wr_count_hi) begin
         nxt_count[15:8] = SFR_WDATA;
      end else begin
         case (mode)
            timer2_pkg::MODE_BAUD: begin
               if (roll) begin
                  nxt_count = rcap_ff;
               end else if (count_inc) begin
                  nxt_count = count_ff + `COUNT_STEP;
               end
            end
            // Capture mode wraps to zero: the reload registers hold the last capture
            timer2_pkg::MODE_CAPTURE: begin
               if (roll) begin
                  nxt_count = `COUNT_WRAP;
               end else if (count_inc) begin
                  nxt_count = count_ff + `COUNT_STEP;
               end
            end
            default: begin
               if (roll || trig_act) begin
                  nxt_count = rcap_ff;
               end else if (count_inc) begin
                  nxt_count = count_ff + `COUNT_STEP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         count_ff <= `COUNT_RESET;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // A capture wins over a software write so the event is never lost
   always_comb begin
      nxt_rcap = rcap_ff;
      if (capture_now) begin
         nxt_rcap = count_ff;
      end else if (wr_rcap_lo) begin
         nxt_rcap[7:0] = SFR_WDATA;
      end else if (wr_rcap_hi) begin
         nxt_rcap[15:8] = SFR_WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rcap_ff <= `RCAP_RESET;
      end else begin
         rcap_ff <= nxt_rcap;
      end
   end

   // Control: byte or bit write first, then hardware sets win over clears
   always_comb begin
      ctrl_bits = ctrl_ff;
      if (wr_ctrl) begin
         ctrl_bits = SFR_WDATA;
      end else if (bit_wr_ctrl) begin
         ctrl_bits[SFR_BIT_ADDR[2:0]] = SFR_BIT_VAL;
      end
      nxt_ctrl = timer2_pkg::ctrl_s'(ctrl_bits);
      if (ovf_set) begin
         nxt_ctrl.overflow_flag = 1'b1;
      end
      if (edge_set) begin
         nxt_ctrl.external_edge_flag = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl_ff <= timer2_pkg::ctrl_s'(`CTRL_RESET);
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // Read mux is decoded every cycle; only the strobe decides when it is captured
   always_comb begin
      rd_mux = `READ_IDLE;
      if (SFR_ADDR == `CTRL_ADDR) begin
         rd_mux = ctrl_ff;
      end else if (SFR_ADDR == `RCAP_LO_ADDR) begin
         rd_mux = rcap_ff[7:0];
      end else if (SFR_ADDR == `RCAP_HI_ADDR) begin
         rd_mux = rcap_ff[15:8];
      end else if (SFR_ADDR == `COUNT_LO_ADDR) begin
         rd_mux = count_ff[7:0];
      end else if (SFR_ADDR == `COUNT_HI_ADDR) begin
         rd_mux = count_ff[15:8];
      end
   end

   // Reads return one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rdata_ff <= `READ_IDLE;
      end else if (SFR_RD) begin
         rdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         bit_rdata_ff <= 1'b0;
      end else if (SFR_BIT_RD) begin
         bit_rdata_ff <= bit_rd_mux;
      end
   end

   function automatic logic ctrl_bits_read(input logic [7:0] value, input logic [2:0] idx);
      ctrl_bits_read = value[idx];
   endfunction

   // Only the primary port is fed; the two selections are steered separately
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rx_tick_ff <= 1'b0;
      end else begin
         rx_tick_ff <= ctrl_ff.rx_baud_select ? roll : OTHER_TIMER_OVF;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         tx_tick_ff <= 1'b0;
      end else begin
         tx_tick_ff <= ctrl_ff.tx_baud_select ? roll : OTHER_TIMER_OVF;
      end
   end

   assign SFR_RDATA = rdata_ff;
   assign SFR_BIT_RDATA = bit_rdata_ff;
   assign RX_BAUD_TICK = rx_tick_ff;
   assign TX_BAUD_TICK = tx_tick_ff;
   // Flag bits come straight from the control register, so a software set also requests
   assign TIMER_INT_REQ = ctrl_ff.overflow_flag | ctrl_ff.external_edge_flag;
endmodule

//--- pin_edge_detect.sv
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
module pin_edge_detect (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_raw,
   pin_edge_if.det edge_out
);
   logic meta_ff;
   logic sync_a_ff;
   logic sync_b_ff;
   logic level_ff;
   logic fall_ff;

   // The first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= 1'b1;
         sync_a_ff <= 1'b1;
         sync_b_ff <= 1'b1;
      end else begin
         meta_ff <= pin_raw;
         sync_a_ff <= meta_ff;
         sync_b_ff <= sync_a_ff;
      end
   end

   // Level idles high so the release of reset never fakes an edge
   always_ff @(posedge clk) begin
      if (rst) begin
         level_ff <= 1'b1;
         fall_ff <= 1'b0;
      end else begin
         if (sync_a_ff == sync_b_ff) begin
            level_ff <= sync_b_ff;
         end
         fall_ff <= level_ff & ~sync_a_ff & ~sync_b_ff;
      end
   end

   assign edge_out.level = level_ff;
   assign edge_out.fall = fall_ff;
endmodule

//--- pin_edge_if.sv
// Carrier for a synchronised pin level and its falling-edge pulse
interface pin_edge_if;
   logic level;
   logic fall;
   modport det (output level, output fall);
   modport use_side (input level, input fall);
endinterface

//--- testbench.sv
// Self-checking bench for the capture/reload timer
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, wr, rd, bwr, bval, brd, spd, trig, cpin, oovf, brdat, rxt, txt, irq;
   logic [7:0] addr, wdat, baddr, rdat;
   logic [15:0] rxc, txc;
   int n_fail, comparisons;
   capture_reload_timer capture_reload_timer_i (.REF_CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr),
      .SFR_WR(wr), .SFR_WDATA(wdat), .SFR_RD(rd), .SFR_RDATA(rdat), .SFR_BIT_ADDR(baddr),
      .SFR_BIT_WR(bwr), .SFR_BIT_VAL(bval), .SFR_BIT_RD(brd), .SFR_BIT_RDATA(brdat),
      .TICK_SPEED_SELECT(spd), .TRIGGER_PIN(trig), .COUNT_INPUT_PIN(cpin),
      .OTHER_TIMER_OVF(oovf), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt), .TIMER_INT_REQ(irq));
   uart_baud_model uart_baud_model_i (.clk(clk), .rst(rst), .rx_tick(rxt), .tx_tick(txt),
      .other_ovf(oovf), .rx_cnt(rxc), .tx_cnt(txc));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   // Strobes drop with an idle cycle after, so back-to-back calls never retrigger in one step
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      {addr, wdat, wr} = {a, d, 1'b1};
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd8(input logic [7:0] a, input logic [7:0] e);
      {addr, rd} = {a, 1'b1};
      cyc(1);
      rd = 1'b0;
      chk8(rdat, e);
      cyc(1);
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr8(a, v[7:0]);
      wr8(a + 8'h01, v[15:8]);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e);
      rd8(a, e[7:0]);
      rd8(a + 8'h01, e[15:8]);
   endtask
   task automatic bw1(input logic [7:0] a, input logic v);
      {baddr, bval, bwr} = {a, v, 1'b1};
      cyc(1);
      bwr = 1'b0;
      cyc(1);
   endtask
   task automatic br1(input logic [7:0] a, input logic e);
      {baddr, brd} = {a, 1'b1};
      cyc(1);
      brd = 1'b0;
      chk1(brdat, e);
      cyc(1);
   endtask
   // Pulses last five clocks each way, well above what the synchroniser can lose
   task automatic pulse(input logic on_trig);
      if (on_trig) trig = 1'b0;
      else cpin = 1'b0;
      cyc(5);
      {trig, cpin} = 2'b11;
      cyc(5);
   endtask
   task automatic t_regs;
      rd8(8'hc8, 8'h00);
      rd16(8'hc9, 16'h0000);
      rd16(8'hcb, 16'h0000);
      rd8(8'hcd, 8'h00);
      bw1(8'hcb, 1'b1);
      bw1(8'hc9, 1'b1);
      rd8(8'hc8, 8'h0a);
      br1(8'hcb, 1'b1);
      br1(8'hd0, 1'b0);
      bw1(8'hcf, 1'b1);
      chk1(irq, 1'b1);
      bw1(8'hcf, 1'b0);
      chk1(irq, 1'b0);
      wr8(8'hc8, 8'h40);
      chk1(irq, 1'b1);
      wr8(8'hc8, 8'h00);
      $display("regs done");
   endtask
   task automatic t_overflow;
      wr16(8'hc9, 16'h1234);
      wr16(8'hcb, 16'hfffe);
      wr8(8'hc8, 8'h06);
      pulse(1'b0);
      rd16(8'hcb, 16'hffff);
      chk1(irq, 1'b0);
      pulse(1'b0);
      chk1(irq, 1'b1);
      rd16(8'hcb, 16'h1234);
      wr8(8'hc8, 8'h82);
      pulse(1'b0);
      rd16(8'hcb, 16'h1234);
      rd8(8'hc8, 8'h82);
      $display("overflow done");
   endtask
   task automatic t_capture;
      wr8(8'hc8, 8'h00);
      wr16(8'hcb, 16'h00f0);
      wr8(8'hc8, 8'h0f);
      pulse(1'b1);
      rd16(8'hc9, 16'h00f0);
      rd8(8'hc8, 8'h4f);
      pulse(1'b0);
      rd16(8'hcb, 16'h00f1);
      wr16(8'hcb, 16'hffff);
      pulse(1'b0);
      rd8(8'hc8, 8'hcf);
      rd16(8'hcb, 16'h0000);
      $display("capture done");
   endtask
   task automatic t_trigger;
      wr8(8'hc8, 8'h02);
      wr16(8'hc9, 16'h1234);
      wr16(8'hcb, 16'h0055);
      pulse(1'b1);
      rd8(8'hc8, 8'h02);
      rd16(8'hcb, 16'h0055);
      wr8(8'hc8, 8'h0a);
      pulse(1'b1);
      rd8(8'hc8, 8'h4a);
      rd16(8'hcb, 16'h1234);
      $display("trigger done");
   endtask
   // Timer mode: 120 counting edges hold exactly 10 slow or 30 fast prescaler ticks
   task automatic t_ticks;
      wr16(8'hcb, 16'h0000);
      wr8(8'hc8, 8'h04);
      cyc(118);
      wr8(8'hc8, 8'h00);
      rd16(8'hcb, 16'h000a);
      spd = 1'b1;
      wr16(8'hcb, 16'h0000);
      wr8(8'hc8, 8'h04);
      cyc(118);
      wr8(8'hc8, 8'h00);
      rd16(8'hcb, 16'h001e);
      spd = 1'b0;
      $display("ticks done");
   endtask
   // Reload fffe overflows every two counts, so own ticks come every four clocks
   task automatic t_baud;
      logic [15:0] r0, t0;
      wr8(8'hc8, 8'h00);
      wr16(8'hc9, 16'hfffe);
      wr16(8'hcb, 16'hfffe);
      {r0, t0} = {rxc, txc};
      wr8(8'hc8, 8'h27);
      cyc(80);
      chk1((rxc - r0) inside {[19:23]}, 1'b1);
      chk1((txc - t0) inside {[7:10]}, 1'b1);
      rd8(8'hc8, 8'h27);
      {r0, t0} = {rxc, txc};
      wr8(8'hc8, 8'h17);
      cyc(80);
      chk1((txc - t0) inside {[19:23]}, 1'b1);
      chk1((rxc - r0) inside {[7:10]}, 1'b1);
      rd8(8'hc8, 8'h17);
      $display("baud done");
   endtask
   task automatic summarize;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Whole run is near 630 clocks; nearly five times that means a hang
   initial begin
      #24000;
      n_fail++;
      summarize();
   end
   initial begin
      {n_fail, comparisons} = '0;
      {addr, wdat, baddr, wr, rd, bwr, bval, brd, spd} = '0;
      {trig, cpin, rst} = 3'b111;
      cyc(2);
      rst = 1'b0;
      t_regs();
      t_overflow();
      t_capture();
      t_trigger();
      t_ticks();
      t_baud();
      summarize();
   end
endmodule

//--- timer2_params.svh
// Constants for the 16-bit capture/reload timer: addresses, bit positions, resets, divisors
// Behaviour
// - Rollover from FFFF sets overflow flag, raising the interrupt request until software clears
// - Overflow flag is never set while either baud select bit is one
// - Software writing one to either flag raises the timer interrupt request
// - With edge enable set, trigger pin falling edge sets the external edge flag
// - Receive baud select picks this timer's or the other timer's overflow
// - Transmit baud select picks this timer's or the other timer's overflow
// - Baud mode counts once per two clocks; counter/timer select is ignored
// - Edge enable permits capture or reload only outside baud mode; zero ignores pin
// - Run control one counts; zero halts counting, but a trigger reload still loads the count bytes
// - Counter/timer select zero counts prescaled ticks; one counts count pin falling edges
// - In baud mode capture select is ignored and every overflow reloads
// - Reload mode overflow loads count high and low from reload registers
// - Reload mode with edge enable: trigger falling edge reloads and sets edge flag
// - Capture mode with edge enable: trigger edge copies count, sets flag, keeps counting
// - Capture mode overflow still sets overflow flag and interrupt request
// - Baud mode overflow reloads from reload registers and forms the baud tick
// - Receive and transmit baud selections act independently
// - Only the primary serial port gets ticks; no secondary port output exists
// - Control register at C8 is byte and bit addressable
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

`define CTRL_ADDR 8'hc8
`define RCAP_LO_ADDR 8'hc9
`define RCAP_HI_ADDR 8'hca
`define COUNT_LO_ADDR 8'hcb
`define COUNT_HI_ADDR 8'hcc
`define CTRL_BIT_BASE 5'h19
`define CTRL_RESET 8'h00
`define RCAP_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define COUNT_WRAP 16'h0000
`define COUNT_STEP 16'h0001
`define TICK_DIV_SLOW 4'hc
`define TICK_DIV_FAST 4'h4
`define PRESC_ONE 4'h1
`define PRESC_RESET 4'h0
`define READ_IDLE 8'h00

`endif

//--- timer2_pkg.sv
// Types shared by the timer modules
package timer2_pkg;
   typedef struct packed {
      logic overflow_flag;
      logic external_edge_flag;
      logic rx_baud_select;
      logic tx_baud_select;
      logic external_edge_enable;
      logic run_control;
      logic counter_select;
      logic capture_reload_select;
   } ctrl_s;

   typedef enum logic [1:0] {
      MODE_RELOAD = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_BAUD = 2'b10
   } mode_e;
endpackage

//--- timer_props.sv
// Port-level assertions for the capture/reload timer
module timer_props (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_BIT_ADDR,
   input wire logic SFR_BIT_WR,
   input wire logic SFR_BIT_VAL,
   input wire logic OTHER_TIMER_OVF,
   input wire logic RX_BAUD_TICK,
   input wire logic TX_BAUD_TICK,
   input wire logic TIMER_INT_REQ
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] shadow_ff;
   logic cw, bw, fw, baud, quiet;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // Only software-owned bits are trusted; hardware sets the flags behind our back
   assign cw = SFR_WR && SFR_ADDR == 8'hc8;
   assign bw = SFR_BIT_WR && !cw && SFR_BIT_ADDR[7:3] == 5'h19;
   assign fw = cw || (bw && SFR_BIT_ADDR[2:1] == 2'b11);
   assign baud = shadow_ff[5] || shadow_ff[4];
   assign quiet = !fw && !TIMER_INT_REQ;
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) shadow_ff <= 8'h00;
      else if (cw) shadow_ff <= SFR_WDATA;
      else if (bw) shadow_ff[SFR_BIT_ADDR[2:0]] <= SFR_BIT_VAL;
   end
   flag_hold_a: assert property (TIMER_INT_REQ && !fw |=> TIMER_INT_REQ)
      else $error("request dropped");
   byte_force_a: assert property (cw && SFR_WDATA[7:6] != 2'b00 |=> TIMER_INT_REQ)
      else $error("byte flag write ignored");
   bit_force_a: assert property (fw && !cw && SFR_BIT_VAL |=> TIMER_INT_REQ)
      else $error("bit flag write ignored");
   baud_quiet_a: assert property (baud && !shadow_ff[3] && quiet |=> !TIMER_INT_REQ)
      else $error("flag set in baud mode");
   stop_quiet_a: assert property (!shadow_ff[2] && !shadow_ff[3] && quiet |=> !TIMER_INT_REQ)
      else $error("flag set while halted");
   rx_other_a: assert property (!shadow_ff[5] && OTHER_TIMER_OVF |=> RX_BAUD_TICK)
      else $error("rx tick lost");
   rx_own_a: assert property (!shadow_ff[5] && !OTHER_TIMER_OVF |=> !RX_BAUD_TICK)
      else $error("rx tick stray");
   tx_other_a: assert property (!shadow_ff[4] && OTHER_TIMER_OVF |=> TX_BAUD_TICK)
      else $error("tx tick lost");
   tx_own_a: assert property (!shadow_ff[4] && !OTHER_TIMER_OVF |=> !TX_BAUD_TICK)
      else $error("tx tick stray");
   baud_pace_a: assert property (shadow_ff[5] && $past(shadow_ff[5]) && RX_BAUD_TICK |=> !RX_BAUD_TICK)
      else $error("baud count too fast");
   own_rx_c: cover property (shadow_ff[5] && RX_BAUD_TICK);
   own_tx_c: cover property (shadow_ff[4] && TX_BAUD_TICK);
   hw_req_c: cover property (quiet ##1 TIMER_INT_REQ);
endmodule
bind capture_reload_timer timer_props timer_props_i (.REF_CLK, .SYS_RST, .SFR_ADDR, .SFR_WR,
   .SFR_WDATA, .SFR_BIT_ADDR, .SFR_BIT_WR, .SFR_BIT_VAL, .OTHER_TIMER_OVF, .RX_BAUD_TICK,
   .TX_BAUD_TICK, .TIMER_INT_REQ);

//--- uart_baud_model.sv
// Primary serial port baud side: counts ticks and paces the other timer
module uart_baud_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_tick,
   input wire logic tx_tick,
   output logic other_ovf,
   output logic [15:0] rx_cnt,
   output logic [15:0] tx_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] div_ff;
   // Other timer every ten clocks, so its ticks never look like ours
   always_ff @(posedge clk) begin
      if (rst) begin
         div_ff <= 4'h0;
         rx_cnt <= 16'h0000;
         tx_cnt <= 16'h0000;
      end else begin
         div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
         rx_cnt <= rx_cnt + {15'h0000, rx_tick};
         tx_cnt <= tx_cnt + {15'h0000, tx_tick};
      end
   end
   assign other_ovf = div_ff == 4'h9;
endmodule
